//--- hw/lpc_pkg.sv
// constants, register layout and state records for the panel control block
// assumes one 25 MHz clock (clk_sys) and a synchronous active-low reset
package lpc_pkg;
    localparam int CLK_PERIOD_NS = 40;

    // indexed register offsets
    localparam logic [7:0] IDX_OVL = 8'h1D;
    localparam logic [7:0] IDX_SHADE = 8'h1E;
    localparam logic [7:0] IDX_BIAS = 8'h1F;
    localparam logic [7:0] IDX_PWR = 8'h20;
    // reset values and writable masks, reserved bits read as zero
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] OVL_WMASK = 8'h46;
    localparam logic [7:0] SHADE_WMASK = 8'hF7;
    localparam logic [7:0] FULL_WMASK = 8'hFF;

    // field positions
    localparam int OVL_SRC_BIT = 6;
    localparam int OVL_SW_LSB = 1;
    localparam int SH_MAP_LSB = 6;
    localparam int SH_RV_TEXT = 5;
    localparam int SH_RV_GFX = 4;
    localparam int SH_OVR = 2;
    localparam int SH_ENH = 1;
    localparam int SH_DITH = 0;
    localparam int BW_SRC = 7;
    localparam int PM_RES = 7;
    localparam int PM_CRT = 6;
    localparam int PM_LCD = 5;
    localparam int PM_TXT_SHADE = 0;

    // field encodings
    localparam logic [1:0] OVL_MODE_EXT = 2'b01;
    localparam logic [1:0] OVL_MODE_INT = 2'b10;
    localparam logic [1:0] PANEL_TYPE_CENTER = 2'b01;
    localparam logic [1:0] MAP_NTSC = 2'b00;
    localparam logic [1:0] MAP_GREEN = 2'b01;
    localparam logic [1:0] MAP_DIRECT = 2'b10;
    localparam logic [7:0] W_RED = 8'h4D;
    localparam logic [7:0] W_GREEN = 8'h96;
    localparam logic [7:0] W_BLUE = 8'h1D;

    // retrace line clocks
    localparam logic [9:0] EXTRA_BASE = 10'h180;
    localparam logic [3:0] EXTRA_GAP_CYC = 4'h8;

    // debounce tick: 30 us and 1.0 s
    localparam int DEB_FINE_NS = 30_000;
    localparam int DEB_FINE_CYC = DEB_FINE_NS / CLK_PERIOD_NS;
    localparam int DEB_COARSE_NS = 1_000_000_000;
    localparam int DEB_COARSE_CYC = DEB_COARSE_NS / CLK_PERIOD_NS;
    localparam int DEB_W = 25;

    // frames between panel power steps
    localparam int STEP_FRAMES = 2;
    localparam int STEP_W = 8;

    typedef enum logic [2:0] {
        PS_OFF = 3'b000,
        PS_VCC = 3'b001,
        PS_DRV = 3'b011,
        PS_BIAS = 3'b010,
        PS_ON = 3'b110
    } lpc_pwr_e;

    typedef struct packed {
        logic [7:0] ovl;
        logic [7:0] shade;
        logic [7:0] bias;
        logic [7:0] pwr;
    } lpc_regs_s;

    typedef struct packed {
        logic [17:0] lut_rgb;
        logic [7:0] pix;
        logic [3:0] fg;
        logic [3:0] bg;
        logic text_mode;
        logic packed_pix;
    } lpc_pix_s;

    typedef struct packed {
        lpc_pwr_e st;
        logic [STEP_W-1:0] frames;
        logic vcc;
        logic drive;
        logic bias;
        logic light;
    } lpc_seq_s;

    typedef struct packed {
        lpc_regs_s regs;
        logic ovl_s1;
        logic ovl_s2;
        logic overlay_timing;
        logic bg_live;
        logic win_live;
        logic conv_en;
        logic [7:0] rdata;
        logic [5:0] gray;
        logic [3:0] fg_out;
        logic [3:0] bg_out;
        logic dither_en;
        logic use_shadow;
        logic ac_bias;
        logic [6:0] mod_cnt;
        logic [9:0] line_cnt;
        logic [3:0] gap_cnt;
        logic line_clk;
        logic extra;
        logic [DEB_W-1:0] deb_cnt;
        logic deb_tick;
        logic crt_en;
    } lpc_state_s;
endpackage

//--- hw/lpc_power_seq.sv
// ordered panel power sequencer, one step per few frames
// assumes frame_tick is a one-cycle pulse on clk_sys
module lpc_power_seq
    import lpc_pkg::*;
#(
    parameter int STEPS = STEP_FRAMES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic want_on,
    input wire logic frame_tick,
    output lpc_seq_s seq
);
    initial begin
        if (STEPS < 1 || STEPS > 255) $error("lpc_power_seq: STEPS out of range");
    end

    lpc_seq_s q;
    lpc_seq_s d;
    logic step_due;

    assign seq = q;
    assign step_due = frame_tick && (32'(q.frames) + 1 >= STEPS);

    always_comb begin
        d = q;
        if (frame_tick) begin
            d.frames = q.frames + 8'h01;
        end
        unique case (q.st)
            PS_OFF: begin
                d.frames = '0;
                if (want_on) begin
                    d.st = PS_VCC;
                end
            end
            PS_VCC: begin
                if (!want_on && step_due) begin
                    d.st = PS_OFF;
                end else if (want_on && step_due) begin
                    d.st = PS_DRV;
                end
            end
            PS_DRV: begin
                if (step_due) begin
                    d.st = want_on ? PS_BIAS : PS_VCC;
                end
            end
            PS_BIAS: begin
                if (!want_on) begin
                    d.st = PS_DRV;
                end else if (step_due) begin
                    d.st = PS_ON;
                end
            end
            PS_ON: begin
                if (!want_on) begin
                    d.st = PS_DRV;
                end
            end
            default: d.st = PS_OFF;
        endcase
        if (d.st != q.st) begin
            d.frames = '0;
        end
        d.vcc = d.st != PS_OFF;
        d.drive = d.st == PS_DRV || d.st == PS_BIAS || d.st == PS_ON;
        d.bias = d.st == PS_BIAS || d.st == PS_ON;
        d.light = d.st == PS_ON;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '{st: PS_OFF, frames: '0, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_seq_nest;
        (q.light |-> q.bias) and (q.bias |-> q.drive) and (q.drive |-> q.vcc);
    endproperty
    a_seq_nest: assert property (p_seq_nest) else $error("panel enables out of order");

    property p_seq_down;
        $fell(q.drive) |-> q.vcc && !q.bias;
    endproperty
    a_seq_down: assert property (p_seq_down) else $error("drive dropped before bias");

    property p_seq_spacing;
        $rose(q.drive) |-> $past(q.vcc) && !q.bias ##1 !q.bias;
    endproperty
    a_seq_spacing: assert property (p_seq_spacing) else $error("steps not spaced");

    c_seq_on: cover property ($rose(q.light));
    c_seq_off: cover property ($fell(q.vcc));
endmodule

//--- hw/lpc_panel_control.sv
// flat panel display control: overlay source, shading, contrast, bias wave,
// retrace line clocks, debounce tick and panel power sequence
// assumes an index/data register port and timing strobes on clk_sys
module lpc_panel_control
    import lpc_pkg::*;
#(
    parameter int DEB_COARSE = DEB_COARSE_CYC,
    parameter int DEB_FINE = DEB_FINE_CYC,
    parameter int PWR_STEPS = STEP_FRAMES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] overlay_mode,
    input wire logic ext_overlay_enable_in_b,
    input wire logic overlay_window_out,
    input wire logic [1:0] panel_type_select,
    input wire logic horiz_centering_on,
    input wire logic text_enhance_aux,
    input wire lpc_pix_s pix_in,
    input wire logic line_tick,
    input wire logic frame_tick,
    input wire logic vblank,
    input wire logic low_power_active,
    input wire logic panel_mode_sel,
    output logic overlay_timing,
    output logic bg_live_video,
    output logic win_live_video,
    output logic ext_conv_en,
    output logic [5:0] gray_level,
    output logic [3:0] text_fg_out,
    output logic [3:0] text_bg_out,
    output logic dither_en,
    output logic use_shadow_horiz,
    output logic panel_ac_bias,
    output logic panel_line_clock,
    output logic debounce_tick,
    output logic monitor_out_en,
    output logic panel_logic_supply_en,
    output logic panel_drive_en,
    output logic panel_bias_supply_en,
    output logic backlight_enable
);
    initial begin
        if (DEB_COARSE < 1 || DEB_COARSE >= (1 << DEB_W)) $error("DEB_COARSE out of range");
        if (DEB_FINE < 1 || DEB_FINE >= DEB_COARSE) $error("DEB_FINE out of range");
    end

    function automatic logic [5:0] ntsc_gray(input logic [17:0] rgb);
        logic [15:0] sum;
        sum = 16'(rgb[17:12] * W_RED) + 16'(rgb[11:6] * W_GREEN) + 16'(rgb[5:0] * W_BLUE);
        return sum[13:8];
    endfunction

    function automatic logic [7:0] reg_write(input logic [7:0] old, input logic [7:0] mask,
                                             input logic [7:0] val);
        return (old & ~mask) | (val & mask);
    endfunction

    lpc_state_s q;
    lpc_state_s d;
    lpc_seq_s seq;
    logic [1:0] sw;
    logic [1:0] map;
    logic [1:0] enh;
    logic [5:0] gray_raw;
    logic [9:0] extra_total;
    logic [DEB_W-1:0] deb_limit;

    // leaving standby/suspend or entering a panel mode reasserts want_on
    lpc_power_seq #(
        .STEPS(PWR_STEPS)
    ) u_seq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .want_on(q.regs.pwr[PM_LCD] && !low_power_active && panel_mode_sel),
        .frame_tick(frame_tick),
        .seq(seq)
    );

    assign sw = q.regs.ovl[OVL_SW_LSB+:2];
    assign enh = {q.regs.shade[SH_ENH], text_enhance_aux};
    // text shading follows the graphics map only when the control bit asks
    assign map = (pix_in.text_mode && !q.regs.pwr[PM_TXT_SHADE]) ? MAP_DIRECT
                                                                   : q.regs.shade[SH_MAP_LSB+:2];
    assign extra_total = EXTRA_BASE + {3'b000, q.regs.bias[6:0]};
    assign deb_limit = q.regs.pwr[PM_RES] ? DEB_W'(DEB_COARSE - 1) : DEB_W'(DEB_FINE - 1);

    always_comb begin
        unique case (map)
            MAP_NTSC: gray_raw = ntsc_gray(pix_in.lut_rgb);
            MAP_GREEN: gray_raw = pix_in.lut_rgb[11:6];
            MAP_DIRECT: gray_raw = pix_in.packed_pix ? pix_in.pix[5:0]
                                                     : {pix_in.pix[3:0], pix_in.pix[3:2]};
            default: gray_raw = 6'h00;
        endcase
    end

    always_comb begin
        d = q;
        d.extra = 1'b0;
        d.deb_tick = 1'b0;
        // register port
        if (reg_wr) begin
            unique case (reg_index)
                IDX_OVL: d.regs.ovl = reg_write(q.regs.ovl, OVL_WMASK, reg_wdata);
                IDX_SHADE: d.regs.shade = reg_write(q.regs.shade, SHADE_WMASK, reg_wdata);
                IDX_BIAS: d.regs.bias = reg_wdata;
                IDX_PWR: d.regs.pwr = reg_wdata;
                default: d.regs = q.regs;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_index)
                IDX_OVL: d.rdata = q.regs.ovl;
                IDX_SHADE: d.rdata = q.regs.shade;
                IDX_BIAS: d.rdata = q.regs.bias;
                IDX_PWR: d.rdata = q.regs.pwr;
                default: d.rdata = 8'h00;
            endcase
        end
        // overlay source; the pin is active low
        d.ovl_s1 = ext_overlay_enable_in_b;
        d.ovl_s2 = q.ovl_s1;
        if (!q.regs.ovl[OVL_SRC_BIT] && overlay_mode == OVL_MODE_EXT) begin
            d.overlay_timing = !q.ovl_s2;
        end else if (q.regs.ovl[OVL_SRC_BIT] && overlay_mode == OVL_MODE_INT) begin
            d.overlay_timing = overlay_window_out;
        end else begin
            d.overlay_timing = 1'b0;
        end
        d.conv_en = !sw[1];
        d.bg_live = sw == 2'b01;
        d.win_live = sw == 2'b00;
        // shading and reverse video
        if (pix_in.text_mode ? q.regs.shade[SH_RV_TEXT] : q.regs.shade[SH_RV_GFX]) begin
            d.gray = ~gray_raw;
        end else begin
            d.gray = gray_raw;
        end
        // contrast enhancement; foreground 1 taken as full intensity
        d.bg_out = pix_in.bg;
        d.fg_out = pix_in.fg;
        unique case (enh)
            2'b01: d.fg_out = (pix_in.bg > pix_in.fg) ? 4'h0 : 4'hF;
            2'b10: begin
                if (pix_in.bg > pix_in.fg) begin
                    d.fg_out = 4'h0;
                end else begin
                    d.bg_out = 4'h0;
                end
            end
            default: d.fg_out = pix_in.fg;
        endcase
        // packed graphics modes keep dithering regardless of the bit; text modes never dither
        d.dither_en = !pix_in.text_mode && (q.regs.shade[SH_DITH] || pix_in.packed_pix);
        d.use_shadow = q.regs.shade[SH_OVR] || (q.regs.pwr[PM_LCD] &&
                       panel_type_select == PANEL_TYPE_CENTER && horiz_centering_on);
        // bias square wave
        if (q.regs.bias[BW_SRC]) begin
            d.mod_cnt = '0;
            d.ac_bias = 1'b0;
        end else if (line_tick) begin
            if (q.mod_cnt >= q.regs.bias[6:0]) begin
                d.mod_cnt = '0;
                d.ac_bias = !q.ac_bias;
            end else begin
                d.mod_cnt = q.mod_cnt + 7'h01;
            end
        end
        // retrace line clocks fill up the per-frame total
        d.gap_cnt = '0;
        if (frame_tick) begin
            d.line_cnt = '0;
        end else if (line_tick) begin
            d.line_cnt = q.line_cnt + 10'h001;
        end else if (q.regs.bias[BW_SRC] && vblank && q.line_cnt < extra_total) begin
            d.gap_cnt = q.gap_cnt + 4'h1;
            if (q.gap_cnt == EXTRA_GAP_CYC - 4'h1) begin
                d.gap_cnt = '0;
                d.extra = 1'b1;
                d.line_cnt = q.line_cnt + 10'h001;
            end
        end
        d.line_clk = line_tick || d.extra;
        // debounce tick
        if (q.deb_cnt >= deb_limit) begin
            d.deb_cnt = '0;
            d.deb_tick = 1'b1;
        end else begin
            d.deb_cnt = q.deb_cnt + DEB_W'(1);
        end
        d.crt_en = q.regs.pwr[PM_CRT];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            q <= '{regs: '{ovl: RST_REG, shade: RST_REG, bias: RST_REG, pwr: RST_REG},
                   ovl_s1: 1'b1, ovl_s2: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign overlay_timing = q.overlay_timing;
    assign bg_live_video = q.bg_live;
    assign win_live_video = q.win_live;
    assign ext_conv_en = q.conv_en;
    assign gray_level = q.gray;
    assign text_fg_out = q.fg_out;
    assign text_bg_out = q.bg_out;
    assign dither_en = q.dither_en;
    assign use_shadow_horiz = q.use_shadow;
    assign panel_ac_bias = q.ac_bias;
    assign panel_line_clock = q.line_clk;
    assign debounce_tick = q.deb_tick;
    assign monitor_out_en = q.crt_en;
    assign panel_logic_supply_en = seq.vcc;
    assign panel_drive_en = seq.drive;
    assign panel_bias_supply_en = seq.bias;
    assign backlight_enable = seq.light;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_ovl_ext;
        !q.regs.ovl[OVL_SRC_BIT] && overlay_mode == OVL_MODE_EXT
            |=> overlay_timing == !$past(q.ovl_s2);
    endproperty
    a_ovl_ext: assert property (p_ovl_ext) else $error("external overlay not followed");

    property p_ovl_int;
        q.regs.ovl[OVL_SRC_BIT] && overlay_mode == OVL_MODE_INT
            |=> overlay_timing == $past(overlay_window_out);
    endproperty
    a_ovl_int: assert property (p_ovl_int) else $error("internal overlay not followed");

    // sampled reset keeps the release edge, where outputs still hold reset values, out
    property p_switch;
        rst_b |=> ext_conv_en == !$past(sw[1]) && bg_live_video == ($past(sw) == 2'b01)
            && win_live_video == ($past(sw) == 2'b00);
    endproperty
    a_switch: assert property (p_switch) else $error("converter switch wrong");

    property p_green_rev;
        map == MAP_GREEN && !pix_in.text_mode && q.regs.shade[SH_RV_GFX]
            |=> gray_level == ~$past(pix_in.lut_rgb[11:6]);
    endproperty
    a_green_rev: assert property (p_green_rev) else $error("green reverse wrong");

    property p_text_rev;
        map == MAP_DIRECT && pix_in.text_mode && pix_in.packed_pix && q.regs.shade[SH_RV_TEXT]
            |=> gray_level == ~$past(pix_in.pix[5:0]);
    endproperty
    a_text_rev: assert property (p_text_rev) else $error("text reverse wrong");

    property p_shadow;
        q.regs.shade[SH_OVR] |=> use_shadow_horiz;
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow timing not chosen");

    property p_contrast;
        enh == 2'b10 && pix_in.bg > pix_in.fg
            |=> text_fg_out == 4'h0 && text_bg_out == $past(pix_in.bg);
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast enhance wrong");

    // the wave is parked low while the retrace clock mode owns the register
    property p_bias_toggle;
        panel_ac_bias != $past(panel_ac_bias)
            |-> ($past(q.regs.bias[BW_SRC]) ? !panel_ac_bias : $past(line_tick));
    endproperty
    a_bias_toggle: assert property (p_bias_toggle) else $error("bias toggled off tick");

    property p_extra;
        q.extra |-> $past(vblank) && $past(q.regs.bias[BW_SRC]) && !$past(line_tick);
    endproperty
    a_extra: assert property (p_extra) else $error("extra clock outside retrace");

    property p_crt;
        ##2 monitor_out_en == $past(q.regs.pwr[PM_CRT], 1);
    endproperty
    a_crt: assert property (p_crt) else $error("monitor enable wrong");

    property p_fine_tick;
        debounce_tick && !q.regs.pwr[PM_RES] |=> !debounce_tick [*2];
    endproperty
    a_fine_tick: assert property (p_fine_tick) else $error("debounce tick too fast");

    c_bias_wave: cover property ($rose(panel_ac_bias));
    c_extra_clk: cover property (q.extra);
    c_overlay: cover property ($rose(overlay_timing));
endmodule

//--- test/lpc_panel_model.sv
// panel glass and supply switch model, counts power order faults
// assumes the four power levels come straight from the control block
module lpc_panel_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic vcc,
    input wire logic drive,
    input wire logic bias,
    input wire logic light,
    output logic [7:0] faults
);
    timeunit 1ns;
    timeprecision 1ns;
    // drive before supply, bias before drive, or light before bias, damages the glass
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            faults <= 8'h00;
        end else if ((drive && !vcc) || (bias && !drive) || (light && !bias)) begin
            faults <= faults + 8'h01;
        end
    end
endmodule

//--- test/tb_lpc_panel_control.sv
// self-checking bench for the panel control block
// assumes lpc_pkg and the panel model are compiled first
module tb_lpc_panel_control
    import lpc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata, faults;
    logic [1:0] ovl_mode = 2'b00, ptype = 2'b00;
    logic ext_b = 1'b1, ovw = 1'b0, ctr = 1'b0, aux = 1'b0, lt = 1'b0, ft = 1'b0;
    logic vb = 1'b0, lp = 1'b0, pm = 1'b1;
    lpc_pix_s pix = '0;
    logic ovt, bgl, wnl, cve, dth, shd, acb, plc, dbt, mon, vcc, drv, bia, bkl;
    logic [5:0] gray;
    logic [3:0] fgo, bgo;
    logic [31:0] seed = 32'h0000_0048;
    int miscompares = 0;
    int total_checks = 0;
    lpc_panel_control #(.DEB_COARSE(200), .DEB_FINE(20), .PWR_STEPS(1)) i_lpc_panel_control (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .overlay_mode(ovl_mode), .ext_overlay_enable_in_b(ext_b), .overlay_window_out(ovw),
        .panel_type_select(ptype), .horiz_centering_on(ctr), .text_enhance_aux(aux),
        .pix_in(pix), .line_tick(lt), .frame_tick(ft), .vblank(vb), .low_power_active(lp),
        .panel_mode_sel(pm), .overlay_timing(ovt), .bg_live_video(bgl), .win_live_video(wnl),
        .ext_conv_en(cve), .gray_level(gray), .text_fg_out(fgo), .text_bg_out(bgo),
        .dither_en(dth), .use_shadow_horiz(shd), .panel_ac_bias(acb),
        .panel_line_clock(plc), .debounce_tick(dbt), .monitor_out_en(mon),
        .panel_logic_supply_en(vcc), .panel_drive_en(drv), .panel_bias_supply_en(bia),
        .backlight_enable(bkl)
    );
    lpc_panel_model i_lpc_panel_model (
        .clk_sys(clk_sys), .rst_b(rst_b), .vcc(vcc), .drive(drv), .bias(bia), .light(bkl),
        .faults(faults)
    );
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // outputs are sampled at the falling edge, well clear of the launch edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_index <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        cyc(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_index <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        cyc(2);
        chk(reg_rdata, exp);
    endtask
    // one-cycle strobe on the line tick (1) or the frame tick (0)
    task automatic pulse(input bit on_line);
        @(posedge clk_sys);
        if (on_line) begin
            lt <= 1'b1;
        end else begin
            ft <= 1'b1;
        end
        @(posedge clk_sys);
        lt <= 1'b0;
        ft <= 1'b0;
    endtask
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (dbt !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            miscompares++;
            end_of_test();
        end
    endtask
    // power pins as {supply, drive, bias, backlight} at the start and after each frame
    task automatic walk(input logic up);
        for (int j = 0; j < (up ? 4 : 3); j++) begin
            if (j > 0) pulse(1'b0);
            cyc(3);
            chk({vcc, drv, bia, bkl}, up ? 4'(~(4'b0111 >> j)) : 4'(4'b1100 << j));
        end
    endtask
    function automatic logic [5:0] ref_gray(logic [7:0] sh, logic tsh, lpc_pix_s p);
        int m, g;
        m = (p.text_mode && !tsh) ? 2 : sh[7:6];
        g = 0;
        if (m == 0) g = (W_RED * p.lut_rgb[17:12] + W_GREEN * p.lut_rgb[11:6]
                         + W_BLUE * p.lut_rgb[5:0]) >> 8;
        if (m == 1) g = p.lut_rgb[11:6];
        if (m == 2) g = p.packed_pix ? p.pix[5:0] : {p.pix[3:0], p.pix[3:2]};
        if (p.text_mode ? sh[5] : sh[4]) g = ~g;
        return g[5:0];
    endfunction
    initial begin
        logic [7:0] idx [5] = '{IDX_OVL, IDX_SHADE, IDX_BIAS, IDX_PWR, 8'h21};
        logic [7:0] msk [5] = '{OVL_WMASK, SHADE_WMASK, FULL_WMASK, FULL_WMASK, 8'h00};
        logic [31:0] s;
        logic [3:0] fe, be;
        logic pa;
        int n, lastt;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(idx[i], 8'h00);
            wr(idx[i], 8'hFF);
            rd(idx[i], msk[i]);
            wr(idx[i], 8'h00);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(IDX_OVL, 8'h40 | 8'(i << 1));
            chk({bgl, wnl, cve}, {i == 1, i == 0, i < 2});
        end
        @(posedge clk_sys);
        ovl_mode <= OVL_MODE_INT;
        ovw <= 1'b1;
        cyc(3);
        chk(ovt, 1);
        wr(IDX_OVL, 8'h00);
        @(posedge clk_sys);
        ovl_mode <= OVL_MODE_EXT;
        ext_b <= 1'b0;
        cyc(5);
        chk(ovt, 1);
        @(posedge clk_sys);
        ext_b <= 1'b1;
        cyc(5);
        chk(ovt, 0);
        $display("test overlay done");
        for (int i = 0; i < 32; i++) begin
            s = xs();
            wr(IDX_SHADE, s[7:0] & 8'hF7);
            wr(IDX_PWR, {1'b0, s[8], 5'h00, s[9]});
            @(posedge clk_sys);
            pix <= lpc_pix_s'({xs(), s[13:10]});
            aux <= s[14];
            cyc(2);
            chk(gray, ref_gray(s[7:0], s[9], pix));
            chk(dth, !pix.text_mode && (s[0] || pix.packed_pix));
            chk({shd, mon}, {s[2], s[8]});
            fe = pix.fg;
            be = pix.bg;
            if ({s[1], s[14]} == 2'b10) begin
                {be, fe} = (pix.bg > pix.fg) ? {pix.bg, 4'h0} : {4'h0, pix.fg};
            end
            if ({s[1], s[14]} == 2'b01) fe = (pix.bg > pix.fg) ? 4'h0 : 4'hF;
            if (pix.text_mode) chk({fgo, bgo}, {fe, be});
        end
        $display("test shading done");
        wr(IDX_BIAS, 8'h02);
        lastt = -1;
        pa = acb;
        for (int k = 0; k < 15; k++) begin
            pulse(1'b1);
            cyc(2);
            if (acb !== pa && lastt >= 0) chk(k - lastt, 3);
            if (acb !== pa) lastt = k;
            pa = acb;
        end
        chk(lastt >= 9, 1);
        wr(IDX_BIAS, 8'h84);
        pulse(1'b0);
        vb <= 1'b1;
        n = 0;
        for (int i = 0; i < 4000; i++) begin
            cyc(1);
            if (plc === 1'b1) n++;
        end
        chk(n, EXTRA_BASE + 10'd4);
        chk(acb, 0);
        @(posedge clk_sys);
        vb <= 1'b0;
        $display("test line clocks done");
        tick_gap(n);
        tick_gap(n);
        chk(n, 20);
        wr(IDX_PWR, 8'h80);
        tick_gap(n);
        tick_gap(n);
        chk(n, 200);
        $display("test debounce done");
        wr(IDX_SHADE, 8'h00);
        repeat (3) pulse(1'b0);
        ptype <= PANEL_TYPE_CENTER;
        ctr <= 1'b1;
        wr(IDX_PWR, 8'h20);
        walk(1);
        chk(shd, 1);
        @(posedge clk_sys);
        lp <= 1'b1;
        walk(0);
        @(posedge clk_sys);
        lp <= 1'b0;
        walk(1);
        @(posedge clk_sys);
        pm <= 1'b0;
        walk(0);
        @(posedge clk_sys);
        pm <= 1'b1;
        walk(1);
        wr(IDX_PWR, 8'h00);
        walk(0);
        chk(faults, 0);
        $display("test power done");
        end_of_test();
    end
endmodule
